// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import txsc_pkg::*;
;
    // clock, reset and register port
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [11:0] REG_ADDR = 12'h000;
    logic [31:0] REG_WDATA = 32'h00000000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    // frame report and length decision
    logic FRAME_DONE = 1'b0;
    logic FRAME_ERR = 1'b0;
    logic FRAME_CTRL = 1'b0;
    logic FRAME_BCAST = 1'b0;
    logic FRAME_UCAST = 1'b0;
    logic FRAME_PAUSE = 1'b0;
    logic [15:0] FRAME_LEN = 16'h0000;
    logic [15:0] FRAME_PAYLOAD_LEN = 16'h0000;
    logic [1:0] FRAME_TAGS = 2'h0;
    logic VLAN_DETECT_OFF = 1'b0;
    logic FRAME_REJECT;
    logic [15:0] FRAME_SENT_LEN;
    // expected live counts and the values reads should show
    logic [63:0] ex [TXSC_NUM_CNT];
    logic [63:0] view [TXSC_NUM_CNT];
    logic [11:0] lo_addr [TXSC_NUM_CNT];
    int n_fail = 0;
    int samples_checked = 0;

    txsc_top txsc_top_i (.MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .FRAME_DONE(FRAME_DONE),
        .FRAME_ERR(FRAME_ERR), .FRAME_CTRL(FRAME_CTRL),
        .FRAME_BCAST(FRAME_BCAST), .FRAME_UCAST(FRAME_UCAST),
        .FRAME_PAUSE(FRAME_PAUSE), .FRAME_LEN(FRAME_LEN),
        .FRAME_PAYLOAD_LEN(FRAME_PAYLOAD_LEN), .FRAME_TAGS(FRAME_TAGS),
        .VLAN_DETECT_OFF(VLAN_DETECT_OFF), .FRAME_REJECT(FRAME_REJECT),
        .FRAME_SENT_LEN(FRAME_SENT_LEN));

    // free running 100 MHz clock
    initial begin
        forever #5 MCLK = ~MCLK;
    end

    // one comparison, counted; a mismatch is told at once
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("fails %0d checks %0d", n_fail, samples_checked);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one-cycle write; an idle cycle after keeps strobes single-driven
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge MCLK);
        REG_WR <= 1'b0;
        @(posedge MCLK);
    endtask

    // data stand only in the cycle after the strobe edge
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
        @(posedge MCLK);
    endtask

    task automatic rd64(input logic [11:0] a, output logic [63:0] d);
        logic [31:0] lo;
        logic [31:0] hi;
        rd(a, lo);
        rd(a + 12'h001, hi);
        d = {hi, lo};
    endtask

    // every counter pair against view, short counter against zero
    task automatic check_all();
        logic [63:0] d;
        for (int i = 0; i < TXSC_NUM_CNT; i++) begin
            rd64(lo_addr[i], d);
            chk(d, view[i]);
        end
        rd64(TXSC_IDX_SHORT_LO, d);
        chk(d, 64'h0);
    endtask

    // drive one report and move the expected counts along with it
    task automatic frame_set(input logic c, input logic b, input logic u,
        input logic p, input logic e, input logic [15:0] len,
        input logic [15:0] pl, input logic [1:0] tg);
        logic [15:0] extra;
        FRAME_DONE <= 1'b1;
        FRAME_CTRL <= c;
        FRAME_BCAST <= b;
        FRAME_UCAST <= u;
        FRAME_PAUSE <= p;
        FRAME_ERR <= e;
        FRAME_LEN <= len;
        FRAME_PAYLOAD_LEN <= pl;
        FRAME_TAGS <= tg;
        extra = 16'h0000;
        if (VLAN_DETECT_OFF && tg == TXSC_TAG_ONE)
            extra = TXSC_VLAN_ONE;
        if (VLAN_DETECT_OFF && tg == TXSC_TAG_TWO)
            extra = TXSC_VLAN_TWO;
        if (!e && len >= TXSC_MIN_LEN) begin
            if (c && b)
                ex[TXSC_C_BCAST] += 64'h1;
            if (c && u)
                ex[TXSC_C_UCAST] += 64'h1;
            if (p)
                ex[TXSC_C_PAUSE] += 64'h1;
            ex[TXSC_C_PAYLOAD] += 64'(pl + extra);
            ex[TXSC_C_FRAME] += 64'(len < TXSC_PAD_LEN ? TXSC_PAD_LEN : len);
        end
    endtask

    // single frame with a look at the length decision
    task automatic frame(input logic c, input logic b, input logic u,
        input logic p, input logic e, input logic [15:0] len,
        input logic [15:0] pl, input logic [1:0] tg);
        frame_set(c, b, u, p, e, len, pl, tg);
        @(posedge MCLK);
        FRAME_DONE <= 1'b0;
        #1 chk(64'(FRAME_REJECT), 64'(len < TXSC_MIN_LEN));
        if (!e && len >= TXSC_MIN_LEN)
            chk(64'(FRAME_SENT_LEN),
                64'(len < TXSC_PAD_LEN ? TXSC_PAD_LEN : len));
        @(posedge MCLK);
    endtask

    // hang guard, far beyond the few hundred cycles of the tests
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    // main sequence
    initial begin
        logic [31:0] d;
        lo_addr = '{TXSC_IDX_BCAST_LO, TXSC_IDX_UCAST_LO, TXSC_IDX_PAUSE_LO,
                    TXSC_IDX_PAYLOAD_LO, TXSC_IDX_FRAME_LO};
        for (int i = 0; i < TXSC_NUM_CNT; i++)
            ex[i] = 64'h0;
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        view = ex;
        check_all();
        rd(TXSC_IDX_STATE, d);
        chk(64'(d), 64'h0);
        rd(12'h840, d);
        chk(64'(d), 64'h0);
        // frame mix: control, pause, data, error, short, padded
        frame(1, 1, 0, 0, 0, 16'h0014, 16'h0006, 2'h0);
        frame(1, 0, 1, 0, 0, 16'h0040, 16'h002E, 2'h1);
        frame(0, 0, 0, 1, 0, 16'h0040, 16'h002E, 2'h0);
        frame(0, 1, 0, 0, 0, 16'h0100, 16'h00F2, 2'h0);
        frame(1, 1, 0, 1, 1, 16'h0050, 16'h0042, 2'h0);
        frame(1, 0, 1, 0, 0, 16'h0008, 16'h0000, 2'h0);
        frame(1, 0, 1, 0, 0, 16'h0009, 16'h0001, 2'h0);
        VLAN_DETECT_OFF <= 1'b1;
        // let the setting land before the expected sums read it
        @(posedge MCLK);
        for (int t = 1; t < 4; t++)
            frame(0, 0, 1, 0, 0, 16'h0080, 16'h0070, 2'(t));
        VLAN_DETECT_OFF <= 1'b0;
        wr(TXSC_IDX_BCAST_LO, 32'hFFFFFFFF);
        view = ex;
        check_all();
        // snapshot held while counting goes on underneath
        wr(TXSC_IDX_CONTROL, 32'h00000004);
        rd(TXSC_IDX_STATE, d);
        chk(64'(d), 64'h2);
        rd(TXSC_IDX_CONTROL, d);
        chk(64'(d), 64'h4);
        frame(1, 1, 0, 1, 0, 16'h0200, 16'h01F2, 2'h0);
        check_all();
        wr(TXSC_IDX_CONTROL, 32'h00000000);
        view = ex;
        check_all();
        rd(TXSC_IDX_STATE, d);
        chk(64'(d), 64'h0);
        // reserved bits, parity clear, reset-all
        wr(TXSC_IDX_CONTROL, 32'hFFFFFFF8);
        rd(TXSC_IDX_CONTROL, d);
        chk(64'(d), 64'h0);
        wr(TXSC_IDX_CONTROL, 32'h00000002);
        rd(TXSC_IDX_CONTROL, d);
        chk(64'(d), 64'h0);
        rd(TXSC_IDX_STATE, d);
        chk(64'(d), 64'h0);
        wr(TXSC_IDX_CONTROL, 32'h00000001);
        rd(TXSC_IDX_CONTROL, d);
        chk(64'(d), 64'h0);
        for (int i = 0; i < TXSC_NUM_CNT; i++)
            ex[i] = 64'h0;
        view = ex;
        check_all();
        // reports on back-to-back cycles, each counted once
        for (int k = 0; k < 4; k++) begin
            frame_set(1, k[0], !k[0], 1, 0, 16'h0041, 16'h0033, 2'h0);
            @(posedge MCLK);
        end
        FRAME_DONE <= 1'b0;
        @(posedge MCLK);
        view = ex;
        check_all();
        // second reset in mid-run clears everything again
        RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        for (int i = 0; i < TXSC_NUM_CNT; i++)
            ex[i] = 64'h0;
        view = ex;
        check_all();
        give_verdict();
    end
endmodule // tb_top

// File: logic/txsc_pkg.sv
package txsc_pkg;
    // register port geometry
    localparam int TXSC_AW = 12;
    localparam int TXSC_DW = 32;
    localparam int TXSC_CW = 64;
    localparam int TXSC_LW = 16;
    // register indices (word addresses on the register port)
    localparam logic [11:0] TXSC_IDX_BCAST_LO = 12'h82E;
    localparam logic [11:0] TXSC_IDX_BCAST_HI = 12'h82F;
    localparam logic [11:0] TXSC_IDX_UCAST_LO = 12'h830;
    localparam logic [11:0] TXSC_IDX_UCAST_HI = 12'h831;
    localparam logic [11:0] TXSC_IDX_PAUSE_LO = 12'h832;
    localparam logic [11:0] TXSC_IDX_PAUSE_HI = 12'h833;
    localparam logic [11:0] TXSC_IDX_SHORT_LO = 12'h834;
    localparam logic [11:0] TXSC_IDX_SHORT_HI = 12'h835;
    localparam logic [11:0] TXSC_IDX_CONTROL = 12'h845;
    localparam logic [11:0] TXSC_IDX_STATE = 12'h846;
    localparam logic [11:0] TXSC_IDX_PAYLOAD_LO = 12'h860;
    localparam logic [11:0] TXSC_IDX_PAYLOAD_HI = 12'h861;
    localparam logic [11:0] TXSC_IDX_FRAME_LO = 12'h862;
    localparam logic [11:0] TXSC_IDX_FRAME_HI = 12'h863;
    // control register field positions
    localparam int TXSC_CFG_SHADOW = 2;
    localparam int TXSC_CFG_PARCLR = 1;
    localparam int TXSC_CFG_RSTALL = 0;
    // state register field positions
    localparam int TXSC_ST_PAUSED = 1;
    localparam int TXSC_ST_PARERR = 0;
    // counter slots
    localparam int TXSC_NUM_CNT = 5;
    localparam int TXSC_C_BCAST = 0;
    localparam int TXSC_C_UCAST = 1;
    localparam int TXSC_C_PAUSE = 2;
    localparam int TXSC_C_PAYLOAD = 3;
    localparam int TXSC_C_FRAME = 4;
    // frame length limits and tag sizes in bytes
    localparam logic [15:0] TXSC_MIN_LEN = 16'h0009;
    localparam logic [15:0] TXSC_PAD_LEN = 16'h0040;
    localparam logic [15:0] TXSC_VLAN_ONE = 16'h0004;
    localparam logic [15:0] TXSC_VLAN_TWO = 16'h0008;
    localparam logic [1:0] TXSC_TAG_ONE = 2'h1;
    localparam logic [1:0] TXSC_TAG_TWO = 2'h2;
    // values after reset, and the counter step of one
    localparam logic [63:0] TXSC_CNT_RST = 64'h0000000000000000;
    localparam logic [31:0] TXSC_WORD_ZERO = 32'h00000000;
    localparam logic [15:0] TXSC_LEN_ZERO = 16'h0000;
    localparam logic [63:0] TXSC_ONE = 64'h0000000000000001;
    // snapshot mode
    typedef enum logic [1:0] {
        TXSC_LIVE = 2'b01,
        TXSC_HELD = 2'b10
    } txsc_mode_t;
endpackage

// File: logic/txsc_top.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// R01: count good broadcast control frames, 64 bits
// R02: count good unicast control frames, 64 bits
// R03: count good pause frames, 64 bits
// R04: short frame counter halves read zero
// R05: frames under nine bytes never sent
// R06: frames of nine bytes up padded to 64
// R07: shadow bit set shows captured snapshot
// R08: live counters keep counting during snapshot
// R09: software writes zero to release snapshot
// R10: parity clear write clears error, self-clears
// R11: reset-all write clears all counters, self-clears
// R12: control bits 31 to 3 reserved
// R13: paused flag follows shadow bit
// R14: parity error flag sticky until cleared
// R15: state bits 31 to 2 reserved
// R16: sum good payload bytes, 64 bits
// R17: vlan detect off adds 4 or 8 bytes
// R18: sum good frame bytes, 64 bits
// R19: low half even index, high next
// R20: update once per finished frame
module txsc_top
    import txsc_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // register port
    input wire logic [TXSC_AW-1:0] REG_ADDR,
    input wire logic [TXSC_DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [TXSC_DW-1:0] REG_RDATA,
    // per-frame report from the transmit path
    input wire logic FRAME_DONE,
    input wire logic FRAME_ERR,
    input wire logic FRAME_CTRL,
    input wire logic FRAME_BCAST,
    input wire logic FRAME_UCAST,
    input wire logic FRAME_PAUSE,
    input wire logic [TXSC_LW-1:0] FRAME_LEN,
    input wire logic [TXSC_LW-1:0] FRAME_PAYLOAD_LEN,
    input wire logic [1:0] FRAME_TAGS,
    // vlan detection off setting of the transmit mac
    input wire logic VLAN_DETECT_OFF,
    // length decision back to the transmit path
    output logic FRAME_REJECT,
    output logic [TXSC_LW-1:0] FRAME_SENT_LEN
);

    // even parity of a counter word
    function automatic logic par_of(input logic [63:0] v);
        par_of = ^v;
    endfunction

    // pick one 32-bit half of a 64-bit value
    function automatic logic [31:0] half_of(input logic [63:0] v,
                                            input logic hi);
        half_of = hi ? v[63:32] : v[31:0];
    endfunction

    // widen a byte count to counter width
    function automatic logic [63:0] wide(input logic [15:0] v);
        wide = {48'h000000000000, v};
    endfunction

    // counter state
    logic [63:0] cnt [TXSC_NUM_CNT]; // live counters
    logic [63:0] next_cnt [TXSC_NUM_CNT];
    logic par [TXSC_NUM_CNT]; // stored parity per counter
    logic next_par [TXSC_NUM_CNT];
    logic [63:0] snap [TXSC_NUM_CNT]; // frozen copy for software
    logic [63:0] next_snap [TXSC_NUM_CNT];
    // control and status state
    txsc_mode_t mode; // live or snapshot shown
    txsc_mode_t next_mode;
    logic par_err; // sticky parity error flag
    logic next_par_err;
    logic [31:0] rdata; // read data register
    logic [31:0] next_rdata;
    logic reject; // short frame refused
    logic next_reject;
    logic [15:0] sent_len; // length after padding
    logic [15:0] next_sent_len;

    // decoded strobes and frame qualifiers
    logic cfg_wr; // write to control register
    logic rst_all; // reset-all request this cycle
    logic par_clr; // parity clear request this cycle
    logic shadow_req; // shadow bit value being written
    logic long_enough; // frame reaches the minimum length
    logic good; // finished frame with no error, at least the minimum length
    logic [15:0] pad_len; // frame length after padding
    logic [15:0] tag_bytes; // vlan bytes to count as payload
    logic [63:0] add [TXSC_NUM_CNT]; // amount per counter
    logic inc [TXSC_NUM_CNT]; // counter update this cycle
    logic par_bad; // any stored parity mismatch
    logic [63:0] shown [TXSC_NUM_CNT]; // values seen by reads

    // control writes act in the write cycle; the two action bits are
    // never stored, so they read back as zero (self-clearing)
    assign cfg_wr = REG_WR && (REG_ADDR == TXSC_IDX_CONTROL);
    assign rst_all = cfg_wr && REG_WDATA[TXSC_CFG_RSTALL]; // [R11]
    assign par_clr = cfg_wr && REG_WDATA[TXSC_CFG_PARCLR]; // [R10]
    assign shadow_req = REG_WDATA[TXSC_CFG_SHADOW];

    // frame qualification, all decided on the done pulse
    assign long_enough = (FRAME_LEN >= TXSC_MIN_LEN); // [R05]
    assign good = FRAME_DONE && !FRAME_ERR && long_enough; // [R20]
    // short frames of legal length go out padded to the minimum
    assign pad_len = (FRAME_LEN < TXSC_PAD_LEN) ? TXSC_PAD_LEN
                                                : FRAME_LEN; // [R06]

    // vlan header bytes count as payload only with detection off
    always_comb begin
        tag_bytes = TXSC_LEN_ZERO;
        if (VLAN_DETECT_OFF) begin
            if (FRAME_TAGS == TXSC_TAG_ONE) begin
                tag_bytes = TXSC_VLAN_ONE; // [R17]
            end else if (FRAME_TAGS == TXSC_TAG_TWO) begin
                tag_bytes = TXSC_VLAN_TWO; // [R17]
            end
        end
    end

    // per-counter increment and amount
    always_comb begin
        inc[TXSC_C_BCAST] = good && FRAME_CTRL && FRAME_BCAST; // [R01]
        inc[TXSC_C_UCAST] = good && FRAME_CTRL && FRAME_UCAST; // [R02]
        inc[TXSC_C_PAUSE] = good && FRAME_PAUSE; // [R03]
        inc[TXSC_C_PAYLOAD] = good; // [R16]
        inc[TXSC_C_FRAME] = good; // [R18]
        add[TXSC_C_BCAST] = TXSC_ONE;
        add[TXSC_C_UCAST] = TXSC_ONE;
        add[TXSC_C_PAUSE] = TXSC_ONE;
        add[TXSC_C_PAYLOAD] = wide(FRAME_PAYLOAD_LEN)
                            + wide(tag_bytes); // [R16] [R17]
        add[TXSC_C_FRAME] = wide(pad_len); // [R18]
    end

    // parity check runs every cycle against the stored bits
    always_comb begin
        par_bad = 1'b0;
        for (int i = 0; i < TXSC_NUM_CNT; i++) begin
            par_bad = par_bad | (par_of(cnt[i]) ^ par[i]);
        end
    end

    // counters: reset-all beats a same-cycle event, since software
    // asked for a clean start at that instant
    always_comb begin
        for (int i = 0; i < TXSC_NUM_CNT; i++) begin
            next_cnt[i] = cnt[i];
            next_par[i] = par[i];
            if (rst_all) begin
                next_cnt[i] = TXSC_CNT_RST; // [R11]
                next_par[i] = 1'b0;
            end else if (inc[i]) begin
                // keeps counting whatever the snapshot mode
                next_cnt[i] = cnt[i] + add[i]; // [R08] [R20]
                next_par[i] = par_of(cnt[i] + add[i]);
            end
        end
    end

    // counter registers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < TXSC_NUM_CNT; i++) begin
                cnt[i] <= TXSC_CNT_RST;
                par[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < TXSC_NUM_CNT; i++) begin
                cnt[i] <= next_cnt[i];
                par[i] <= next_par[i];
            end
        end
    end

    // snapshot mode: capture on entry, hold until software writes 0
    always_comb begin
        next_mode = mode;
        for (int i = 0; i < TXSC_NUM_CNT; i++) begin
            next_snap[i] = snap[i];
        end
        case (mode)
            TXSC_LIVE: begin
                if (cfg_wr && shadow_req) begin
                    next_mode = TXSC_HELD; // [R07]
                    for (int i = 0; i < TXSC_NUM_CNT; i++) begin
                        // values as they stand at the write
                        next_snap[i] = cnt[i]; // [R07]
                    end
                end
            end
            TXSC_HELD: begin
                if (cfg_wr && !shadow_req) begin
                    next_mode = TXSC_LIVE; // [R09]
                end
            end
            default: begin
                next_mode = TXSC_LIVE;
            end
        endcase
    end

    // snapshot registers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            mode <= TXSC_LIVE;
            for (int i = 0; i < TXSC_NUM_CNT; i++) begin
                snap[i] <= TXSC_CNT_RST;
            end
        end else begin
            mode <= next_mode;
            for (int i = 0; i < TXSC_NUM_CNT; i++) begin
                snap[i] <= next_snap[i];
            end
        end
    end

    // reads see the snapshot while held, the live count otherwise
    always_comb begin
        for (int i = 0; i < TXSC_NUM_CNT; i++) begin
            shown[i] = (mode == TXSC_HELD) ? snap[i] : cnt[i]; // [R07]
        end
    end

    // sticky parity flag: a new error wins over a same-cycle clear
    always_comb begin
        next_par_err = par_err;
        if (par_clr) begin
            next_par_err = 1'b0; // [R10]
        end
        if (par_bad) begin
            next_par_err = 1'b1; // [R14]
        end
    end

    // read mux; data is valid only in the cycle after the strobe
    always_comb begin
        next_rdata = TXSC_WORD_ZERO;
        if (REG_RD) begin
            case (REG_ADDR)
                TXSC_IDX_BCAST_LO, TXSC_IDX_BCAST_HI: begin
                    next_rdata = half_of(shown[TXSC_C_BCAST],
                                         REG_ADDR[0]); // [R01] [R19]
                end
                TXSC_IDX_UCAST_LO, TXSC_IDX_UCAST_HI: begin
                    next_rdata = half_of(shown[TXSC_C_UCAST],
                                         REG_ADDR[0]); // [R02] [R19]
                end
                TXSC_IDX_PAUSE_LO, TXSC_IDX_PAUSE_HI: begin
                    next_rdata = half_of(shown[TXSC_C_PAUSE],
                                         REG_ADDR[0]); // [R03] [R19]
                end
                TXSC_IDX_SHORT_LO, TXSC_IDX_SHORT_HI: begin
                    // nothing short ever leaves, so nothing to count
                    next_rdata = TXSC_WORD_ZERO; // [R04]
                end
                TXSC_IDX_CONTROL: begin
                    // only the shadow bit is stored; upper bits zero
                    next_rdata[TXSC_CFG_SHADOW] =
                        (mode == TXSC_HELD); // [R12]
                end
                TXSC_IDX_STATE: begin
                    next_rdata[TXSC_ST_PAUSED] =
                        (mode == TXSC_HELD); // [R13] [R15]
                    next_rdata[TXSC_ST_PARERR] = par_err; // [R14]
                end
                TXSC_IDX_PAYLOAD_LO, TXSC_IDX_PAYLOAD_HI: begin
                    next_rdata = half_of(shown[TXSC_C_PAYLOAD],
                                         REG_ADDR[0]); // [R16] [R19]
                end
                TXSC_IDX_FRAME_LO, TXSC_IDX_FRAME_HI: begin
                    next_rdata = half_of(shown[TXSC_C_FRAME],
                                         REG_ADDR[0]); // [R18] [R19]
                end
                default: begin
                    // unmapped and reserved indices read zero
                    next_rdata = TXSC_WORD_ZERO;
                end
            endcase
        end
    end

    // length decision reported back for each finished frame
    always_comb begin
        next_reject = FRAME_DONE && !long_enough; // [R05]
        next_sent_len = sent_len;
        if (FRAME_DONE && long_enough) begin
            next_sent_len = pad_len; // [R06]
        end
    end

    // status, read and length registers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            par_err <= 1'b0;
            rdata <= TXSC_WORD_ZERO;
            reject <= 1'b0;
            sent_len <= TXSC_LEN_ZERO;
        end else begin
            par_err <= next_par_err;
            rdata <= next_rdata;
            reject <= next_reject;
            sent_len <= next_sent_len;
        end
    end

    assign REG_RDATA = rdata;
    assign FRAME_REJECT = reject;
    assign FRAME_SENT_LEN = sent_len;

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // a read strobe at a given index
    sequence s_read(logic [11:0] idx);
        REG_RD && (REG_ADDR == idx);
    endsequence

    // a write of one control bit
    sequence s_cfg_bit(int b);
        cfg_wr && REG_WDATA[b];
    endsequence

    chk_bcast_count: assert property ( // [R01]
        good && FRAME_CTRL && FRAME_BCAST && !rst_all |=>
        cnt[TXSC_C_BCAST] == $past(cnt[TXSC_C_BCAST]) + TXSC_ONE)
        else $error("broadcast control count missed a frame");

    chk_ucast_count: assert property ( // [R02]
        good && FRAME_CTRL && FRAME_UCAST && !rst_all |=>
        cnt[TXSC_C_UCAST] == $past(cnt[TXSC_C_UCAST]) + TXSC_ONE)
        else $error("unicast control count missed a frame");

    chk_pause_idle: assert property ( // [R03]
        !(good && FRAME_PAUSE) && !rst_all |=>
        $stable(cnt[TXSC_C_PAUSE]))
        else $error("pause count moved without a pause frame");

    chk_short_zero: assert property ( // [R04]
        s_read(TXSC_IDX_SHORT_LO) or s_read(TXSC_IDX_SHORT_HI) |=>
        REG_RDATA == TXSC_WORD_ZERO)
        else $error("short frame counter read nonzero");

    chk_short_reject: assert property ( // [R05]
        FRAME_DONE && (FRAME_LEN < TXSC_MIN_LEN) && !rst_all |=>
        FRAME_REJECT && $stable(cnt[TXSC_C_FRAME]))
        else $error("frame under minimum length was accepted");

    chk_pad_len: assert property ( // [R06]
        good && (FRAME_LEN < TXSC_PAD_LEN) && !rst_all |=>
        FRAME_SENT_LEN == TXSC_PAD_LEN &&
        cnt[TXSC_C_FRAME] == $past(cnt[TXSC_C_FRAME]) + 64'h40)
        else $error("short frame not padded to minimum");

    chk_snap_hold: assert property ( // [R07]
        mode == TXSC_HELD && !(cfg_wr && !shadow_req) |=>
        $stable(snap[TXSC_C_FRAME]) && mode == TXSC_HELD)
        else $error("snapshot changed while held");

    chk_snap_live: assert property ( // [R08]
        mode == TXSC_HELD && good && !rst_all |=>
        cnt[TXSC_C_FRAME] != $past(cnt[TXSC_C_FRAME]) ||
        $past(pad_len) == TXSC_LEN_ZERO)
        else $error("live counter stalled during snapshot");

    chk_parity_clear: assert property ( // [R10]
        s_cfg_bit(TXSC_CFG_PARCLR) ##0 !par_bad |=> !par_err ##1
        (par_err == $past(par_bad, 1) || par_err))
        else $error("parity clear did not clear the flag");

    chk_reset_all: assert property ( // [R11]
        s_cfg_bit(TXSC_CFG_RSTALL) |=>
        cnt[TXSC_C_BCAST] == TXSC_CNT_RST &&
        cnt[TXSC_C_PAYLOAD] == TXSC_CNT_RST)
        else $error("reset-all left a counter nonzero");

    chk_ctrl_resv: assert property ( // [R12]
        s_read(TXSC_IDX_CONTROL) |=> REG_RDATA[31:3] == 29'h0 &&
        REG_RDATA[1:0] == 2'h0)
        else $error("control reserved or action bits read set");

    chk_paused_flag: assert property ( // [R13]
        s_read(TXSC_IDX_STATE) |=>
        REG_RDATA[TXSC_ST_PAUSED] == ($past(mode) == TXSC_HELD))
        else $error("paused flag disagrees with shadow mode");

    chk_parerr_sticky: assert property ( // [R14]
        par_err && !par_clr |=> par_err ##1 (par_err || $past(par_clr)))
        else $error("parity error flag dropped on its own");

    chk_state_resv: assert property ( // [R15]
        s_read(TXSC_IDX_STATE) |=> REG_RDATA[31:2] == 30'h0)
        else $error("state reserved bits read set");

    chk_vlan_bytes: assert property ( // [R16] [R17]
        good && VLAN_DETECT_OFF && FRAME_TAGS == TXSC_TAG_TWO &&
        !rst_all |=> cnt[TXSC_C_PAYLOAD] == $past(cnt[TXSC_C_PAYLOAD])
        + wide($past(FRAME_PAYLOAD_LEN)) + 64'h8)
        else $error("stacked tag bytes not added to payload");

    chk_high_half: assert property ( // [R19]
        s_read(TXSC_IDX_FRAME_HI) |=>
        REG_RDATA == $past(shown[TXSC_C_FRAME][63:32]))
        else $error("high half read wrong word");

    chk_once_per_frame: assert property ( // [R18] [R20]
        !FRAME_DONE && !rst_all |=> $stable(cnt[TXSC_C_FRAME]) &&
        $stable(cnt[TXSC_C_PAYLOAD]))
        else $error("octet counter moved without a finished frame");

endmodule // txsc_top
